// *** core/power_saving_mode_control.sv ***
`timescale 1ns/10ps
// Contract
// - pin high blocks every power mode entry
// - pin high in reset autostarts watchdog
// - pin low enables modes, no autostart
// - later pin changes never touch watchdog
// - pin level sampled at state 3 phase 1
// - two general flags, plain read/write
// - clock divide bit enables slow-down
// - idle gates cpu clock, peripherals run
// - cpu state frozen during idle
// - port pins hold levels in idle
// - strobes held high during idle
// - port inputs stay live in idle
// - watchdog halted throughout idle
// - idle needs arm write, then start write
// - arm and start together never enter idle
// - arm/start bits self-clear, read zero
// - start instruction is last before idle
// - power-down arm then start, start last
// - both modes need sequence and pin
// - power-down arm bit1, start bit6
// - slow-down within two cycles, divide eight
// - enabled interrupt ends idle
module power_saving_mode_control (
  input  wire logic       clk_sys,                        // oscillator clock
  input  wire logic       rst_n,                          // async reset
  input  wire logic       save_enable_watchdog_start_pin, // external pin
  input  wire logic [7:0] sfr_addr,                       // sfr address
  input  wire logic       sfr_wr,                         // sfr write strobe
  input  wire logic [7:0] sfr_wdata,                      // sfr write data
  input  wire logic       instr_end,                      // last cycle of instruction
  input  wire logic       irq_pending,                    // enabled interrupt active
  output logic      [7:0] sfr_rdata,                      // sfr read data
  output logic            cpu_clk_en,                     // cpu clock gate
  output logic            periph_clk_en,                  // peripheral clock gate
  output logic            osc_tick,                       // divided clock enable
  output logic            slow_active,                    // slow-down in force
  output logic            sleep_active,                   // idle mode
  output logic            powerdown_active,               // power-down mode
  output logic            wdt_halt,                       // watchdog stop
  output logic            wdt_autostart,                  // watchdog started by strap
  output logic            port_hold,                      // freeze port levels
  output logic            ale_hold_high,                  // address strobe forced high
  output logic            program_store_strobe_high       // store strobe forced high
);
  // ----------------------------------------
  // pin synchroniser and sampling
  // ----------------------------------------
  logic       pin_meta;    // first stage, read only by pin_sync
  logic       pin_sync;    // second stage
  logic       pe_block;    // pin level seen at sample point
  logic [3:0] mc_pos;      // position in machine cycle
  logic [2:0] div_cnt;     // slow-down prescaler
  logic [1:0] strap_cnt;   // cycles since reset release

  // two flops; reset to pull-up level so modes start blocked
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta <= pwr_pkg::PIN_RESET_LEVEL;
      pin_sync <= pwr_pkg::PIN_RESET_LEVEL;
    end else begin
      pin_meta <= save_enable_watchdog_start_pin;
      pin_sync <= pin_meta;
    end
  end

  // prescaler: every clock normally, every eighth when slowed
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 3'h0;
    end else if (!slow_active || div_cnt == pwr_pkg::SLOW_DIV_LAST) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  assign osc_tick = !slow_active || div_cnt == pwr_pkg::SLOW_DIV_LAST;

  // machine cycle position, advances on each oscillator tick
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc_pos <= 4'h0;
    end else if (osc_tick) begin
      mc_pos <= (mc_pos == pwr_pkg::MC_LAST) ? 4'h0 : mc_pos + 4'h1;
    end
  end

  // level change only seen at s3p1; between samples it stands still
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pe_block <= pwr_pkg::PIN_RESET_LEVEL;
    end else if (osc_tick && mc_pos == pwr_pkg::MC_S3P1) begin
      pe_block <= pin_sync;
    end
  end

  // ----------------------------------------
  // watchdog strap
  // ----------------------------------------
  // caught once after release, once the synchroniser carries the pin;
  // nothing later can change it, so pin toggles leave the watchdog alone
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt     <= 2'h0;
      wdt_autostart <= 1'b0;
    end else if (strap_cnt != pwr_pkg::STRAP_DONE) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == pwr_pkg::STRAP_SAMPLE) begin
        wdt_autostart <= pin_sync;
      end
    end
  end

  // ----------------------------------------
  // register
  // ----------------------------------------
  logic       ctl_hit;       // write to power_mode_control
  logic       clock_divide_enable;
  logic       general_flag_zero;
  logic       general_flag_one;
  logic       w_sleep_arm;   // arm-only write
  logic       w_sleep_start; // start-only write
  logic       w_pd_arm;
  logic       w_pd_start;

  assign ctl_hit = sfr_wr && sfr_addr == pwr_pkg::ADDR_POWER_MODE_CONTROL;
  // a write setting both bits of a pair counts as neither
  // byte writes only: a read-modify-write that keeps an old arm bit set
  // alongside a new start bit is refused like any combined write
  assign w_sleep_arm   = ctl_hit && sfr_wdata[pwr_pkg::BIT_SLEEP_ARM]
                         && !sfr_wdata[pwr_pkg::BIT_SLEEP_START];
  assign w_sleep_start = ctl_hit && sfr_wdata[pwr_pkg::BIT_SLEEP_START]
                         && !sfr_wdata[pwr_pkg::BIT_SLEEP_ARM];
  assign w_pd_arm      = ctl_hit && sfr_wdata[pwr_pkg::BIT_POWERDOWN_ARM]
                         && !sfr_wdata[pwr_pkg::BIT_POWERDOWN_START];
  assign w_pd_start    = ctl_hit && sfr_wdata[pwr_pkg::BIT_POWERDOWN_START]
                         && !sfr_wdata[pwr_pkg::BIT_POWERDOWN_ARM];

  // stored bits; the frozen cpu cannot write while idle anyway
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clock_divide_enable <= pwr_pkg::RESET_POWER_MODE_CONTROL[pwr_pkg::BIT_CLOCK_DIVIDE];
      general_flag_zero   <= pwr_pkg::RESET_POWER_MODE_CONTROL[pwr_pkg::BIT_GENERAL_ZERO];
      general_flag_one    <= pwr_pkg::RESET_POWER_MODE_CONTROL[pwr_pkg::BIT_GENERAL_ONE];
    end else if (ctl_hit) begin
      clock_divide_enable <= sfr_wdata[pwr_pkg::BIT_CLOCK_DIVIDE];
      general_flag_zero   <= sfr_wdata[pwr_pkg::BIT_GENERAL_ZERO];
      general_flag_one    <= sfr_wdata[pwr_pkg::BIT_GENERAL_ONE];
    end
  end

  // arm and start bits never stored, so they always read zero
  always_comb begin
    sfr_rdata = 8'h00;
    sfr_rdata[pwr_pkg::BIT_CLOCK_DIVIDE] = clock_divide_enable;
    sfr_rdata[pwr_pkg::BIT_GENERAL_ZERO] = general_flag_zero;
    sfr_rdata[pwr_pkg::BIT_GENERAL_ONE]  = general_flag_one;
  end

  // ----------------------------------------
  // arm tracking
  // ----------------------------------------
  logic sleep_armed; // arm seen
  logic sleep_aged;  // arming instruction has ended
  logic pd_armed;
  logic pd_aged;
  logic sleep_req;   // entry pending end of start instruction
  logic pd_req;

  // arm lives only through the next instruction, then is dropped
  // a lone start write finds no aged arm and falls away, so a runaway
  // program cannot park the cpu with one stray store
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_armed <= 1'b0;
      sleep_aged  <= 1'b0;
    end else if (w_sleep_arm) begin
      sleep_armed <= 1'b1;
      sleep_aged  <= 1'b0;
    end else if (w_sleep_start || (instr_end && sleep_aged)) begin
      sleep_armed <= 1'b0;
      sleep_aged  <= 1'b0;
    end else if (instr_end && sleep_armed) begin
      sleep_aged <= 1'b1;
    end
  end

  // same sequence for power-down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pd_armed <= 1'b0;
      pd_aged  <= 1'b0;
    end else if (w_pd_arm) begin
      pd_armed <= 1'b1;
      pd_aged  <= 1'b0;
    end else if (w_pd_start || (instr_end && pd_aged)) begin
      pd_armed <= 1'b0;
      pd_aged  <= 1'b0;
    end else if (instr_end && pd_armed) begin
      pd_aged <= 1'b1;
    end
  end

  // start accepted only right after arm and with the pin permitting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_req <= 1'b0;
      pd_req    <= 1'b0;
    end else begin
      if (w_sleep_start && sleep_aged && !pe_block) begin
        sleep_req <= 1'b1;
      end else if (instr_end) begin
        sleep_req <= 1'b0;
      end
      if (w_pd_start && pd_aged && !pe_block) begin
        pd_req <= 1'b1;
      end else if (instr_end) begin
        pd_req <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // mode state
  // ----------------------------------------
  // entry waits for the start instruction to end; power-down wins;
  // power-down leaves only by reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sleep_active     <= 1'b0;
      powerdown_active <= 1'b0;
    end else if (instr_end && pd_req) begin
      powerdown_active <= 1'b1;
      sleep_active     <= 1'b0;
    end else if (instr_end && sleep_req) begin
      sleep_active <= 1'b1;
    end else if (sleep_active && irq_pending) begin
      sleep_active <= 1'b0;
    end
  end

  // slow-down taken at machine cycle end, within two cycles; pin blocks it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slow_active <= 1'b0;
    end else if (osc_tick && mc_pos == pwr_pkg::MC_LAST) begin
      slow_active <= clock_divide_enable && !pe_block;
    end
  end

  // ----------------------------------------
  // gates and pin controls
  // ----------------------------------------
  // cpu clock off freezes all cpu registers; peripherals keep clocking in idle, stop in power-down
  assign cpu_clk_en    = !sleep_active && !powerdown_active;
  assign periph_clk_en = !powerdown_active;
  assign wdt_halt      = sleep_active || powerdown_active;
  assign port_hold     = sleep_active || powerdown_active;
  assign ale_hold_high = sleep_active;
  assign program_store_strobe_high = sleep_active;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // entry edge traces back to the start write, taken one edge earlier
  a_block_entry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(sleep_active) || $rose(powerdown_active) |-> $past(!pe_block))
    else $error("mode entered while pin blocked");
  a_cpu_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sleep_active |-> !cpu_clk_en && periph_clk_en)
    else $error("idle clock gating wrong");
  a_wdt_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sleep_active |-> wdt_halt)
    else $error("watchdog runs in idle");
  a_strobes_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sleep_active |-> ale_hold_high && program_store_strobe_high && port_hold)
    else $error("strobes not held in idle");
  a_arm_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sfr_rdata[pwr_pkg::BIT_SLEEP_ARM] == 1'b0 && sfr_rdata[pwr_pkg::BIT_SLEEP_START] == 1'b0)
    else $error("arm or start bit reads one");
  a_both_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ctl_hit && sfr_wdata[pwr_pkg::BIT_SLEEP_ARM] && sfr_wdata[pwr_pkg::BIT_SLEEP_START]
    && !sleep_req |=> !sleep_req)
    else $error("combined write started idle");
  a_strap_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(wdt_autostart) |-> $past(strap_cnt) == pwr_pkg::STRAP_SAMPLE)
    else $error("watchdog start changed late");
  a_pin_sample: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $changed(pe_block) |-> $past(mc_pos) == pwr_pkg::MC_S3P1)
    else $error("pin sampled off s3p1");
  a_slow_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clock_divide_enable && !pe_block && !slow_active ##1
    clock_divide_enable && !pe_block |-> ##[0:23] slow_active)
    else $error("slow-down late");
  a_idle_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sleep_active && irq_pending && !pd_req |=> !sleep_active)
    else $error("idle not ended by interrupt");
endmodule

// *** core/pwr_pkg.sv ***
package pwr_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADDR_POWER_MODE_CONTROL = 8'h87; // sfr address
  localparam logic [7:0] RESET_POWER_MODE_CONTROL = 8'h00; // all modes off
  // ----------------------------------------
  // field positions inside power_mode_control
  // ----------------------------------------
  localparam int BIT_SLEEP_ARM     = 0; // idle arm
  localparam int BIT_POWERDOWN_ARM = 1; // power-down arm
  localparam int BIT_GENERAL_ZERO  = 2; // general flag zero
  localparam int BIT_GENERAL_ONE   = 3; // general flag one
  localparam int BIT_CLOCK_DIVIDE  = 4; // slow-down enable
  localparam int BIT_SLEEP_START   = 5; // idle start
  localparam int BIT_POWERDOWN_START = 6; // power-down start
  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  localparam logic [3:0] MC_LAST      = 4'hB; // 6 states x 2 phases
  localparam logic [3:0] MC_S3P1      = 4'h4; // pin sample point
  localparam logic [2:0] SLOW_DIV_LAST = 3'h7; // divide by eight
  localparam logic [1:0] STRAP_SAMPLE = 2'h2; // sync chain settled
  localparam logic [1:0] STRAP_DONE   = 2'h3; // strap caught
  localparam logic       PIN_RESET_LEVEL = 1'b1; // weak pull-up default
endpackage

// *** sim/fail_signal_model.sv ***
`timescale 1ns/10ps
// ----------------------------------------
// power-fail circuitry at the enable pin
// ----------------------------------------
module fail_signal_model (
  input  wire logic clk_sys,    // board clock
  input  wire logic power_fail, // bench command: supply failing
  output logic      pin_level   // level seen at the enable pin
);
  logic pull_low; // pin pulled down by the fail circuit

  // fail warning registered, as a real comparator output settles late
  always_ff @(posedge clk_sys) begin
    pull_low <= power_fail;
  end

  // released pin goes to the weak pull-up level, never to a stale value
  assign pin_level = (pull_low === 1'b1) ? 1'b0 : 1'b1;
endmodule

// *** sim/power_saving_mode_control_bench.sv ***
`timescale 1ns/10ps
module power_saving_mode_control_bench;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [7:0] CTL_ADDR = pwr_pkg::ADDR_POWER_MODE_CONTROL; // control register
  localparam int         SLOW_WAIT = 200; // two slowed machine cycles, 96 clocks each
  logic       clk_sys;                        // 10 MHz clock
  logic       rst_n;                          // async reset
  logic       power_fail;                     // command to the pin model
  logic       save_enable_watchdog_start_pin; // pin from the model
  logic [7:0] sfr_addr;                       // register address
  logic       sfr_wr;                         // write strobe
  logic [7:0] sfr_wdata;                      // write data
  logic       instr_end;                      // instruction boundary
  logic       irq_pending;                    // wake request
  logic [7:0] sfr_rdata;                      // read data
  logic       cpu_clk_en;                     // cpu clock gate
  logic       periph_clk_en;                  // peripheral gate
  logic       osc_tick;                       // divided clock enable
  logic       slow_active;                    // slow-down state
  logic       sleep_active;                   // idle state
  logic       powerdown_active;               // power-down state
  logic       wdt_halt;                       // watchdog stop
  logic       wdt_autostart;                  // strap result
  logic       port_hold;                      // port freeze
  logic       ale_hold_high;                  // address strobe high
  logic       program_store_strobe_high;      // store strobe high
  int         fails;                          // mismatch count
  int         tests_run;                      // compare count
  int         n_ticks;                        // osc_tick pulses seen

  // ----------------------------------------
  // instances
  // ----------------------------------------
  power_saving_mode_control i_power_saving_mode_control (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .save_enable_watchdog_start_pin(save_enable_watchdog_start_pin),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata),
    .instr_end(instr_end), .irq_pending(irq_pending), .sfr_rdata(sfr_rdata),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_tick(osc_tick),
    .slow_active(slow_active), .sleep_active(sleep_active),
    .powerdown_active(powerdown_active), .wdt_halt(wdt_halt),
    .wdt_autostart(wdt_autostart), .port_hold(port_hold),
    .ale_hold_high(ale_hold_high), .program_store_strobe_high(program_store_strobe_high)
  );
  fail_signal_model i_fail_signal_model (
    .clk_sys(clk_sys), .power_fail(power_fail), .pin_level(save_enable_watchdog_start_pin)
  );

  // free-running clock, 100 ns period
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  // all stimulus moves on the falling edge, away from sampling
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] expected);
    tests_run++;
    if (seen !== expected) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expected);
    end
  endtask

  // one instruction: optional write cycle, then its boundary cycle
  task automatic instr(input logic [7:0] addr, input logic [7:0] data, input logic do_wr);
    sfr_addr  = addr;
    sfr_wdata = data;
    sfr_wr    = do_wr;
    tick(1);
    sfr_wr    = 1'b0;
    instr_end = 1'b1;
    tick(1);
    instr_end = 1'b0;
  endtask

  // 20-cycle reset, then time for strap and the first pin sample
  task automatic do_reset(input logic fail);
    rst_n      = 1'b0;
    power_fail = fail;
    tick(20);
    rst_n = 1'b1;
    tick(30);
  endtask

  // slow-down follows within two machine cycles; leaving it takes slowed
  // cycles, so the bound covers the long case; longer counts a hang
  task automatic wait_slow(input logic expected);
    int k;
    k = 0;
    while (slow_active !== expected && k < SLOW_WAIT) begin
      tick(1);
      k++;
    end
    check({7'h00, slow_active}, {7'h00, expected});
    if (k == SLOW_WAIT) wrap_up();
  endtask

  task automatic wrap_up();
    $display("fails=%0d tests_run=%0d", fails, tests_run);
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0; power_fail = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0;
    sfr_wdata = 8'h00; instr_end = 1'b0; irq_pending = 1'b0;
    fails = 0; tests_run = 0;
    // pin left high: everything blocked, watchdog strapped on
    do_reset(1'b0);
    check({7'h00, wdt_autostart}, 8'h01);
    check(sfr_rdata, 8'h00);
    instr(CTL_ADDR, 8'h01, 1'b1);
    instr(CTL_ADDR, 8'h20, 1'b1);
    check({7'h00, sleep_active}, 8'h00);
    instr(CTL_ADDR, 8'h02, 1'b1);
    instr(CTL_ADDR, 8'h40, 1'b1);
    check({7'h00, powerdown_active}, 8'h00);
    instr(CTL_ADDR, 8'h10, 1'b1);
    tick(30);
    check({7'h00, slow_active}, 8'h00);
    // pin held low through reset: modes open, no autostart
    do_reset(1'b1);
    check({7'h00, wdt_autostart}, 8'h00);
    instr(CTL_ADDR, 8'h0C, 1'b1);
    check(sfr_rdata, 8'h0C);
    instr(8'h88, 8'hFF, 1'b1);
    check(sfr_rdata, 8'h0C);
    // arm and start in one write
    instr(CTL_ADDR, 8'h23, 1'b1);
    check({7'h00, sleep_active}, 8'h00);
    check(sfr_rdata, 8'h00);
    // arm aged by an unrelated instruction
    instr(CTL_ADDR, 8'h01, 1'b1);
    check(sfr_rdata, 8'h00);
    instr(8'h00, 8'h00, 1'b0);
    instr(CTL_ADDR, 8'h20, 1'b1);
    check({7'h00, sleep_active}, 8'h00);
    // proper idle entry, outputs checked the cycle after the start
    instr(CTL_ADDR, 8'h01, 1'b1);
    instr(CTL_ADDR, 8'h20, 1'b1);
    check({sleep_active, cpu_clk_en, periph_clk_en, wdt_halt, port_hold,
           ale_hold_high, program_store_strobe_high, 1'b0}, 8'hBE);
    irq_pending = 1'b1;
    tick(1);
    irq_pending = 1'b0;
    check({6'h00, sleep_active, cpu_clk_en}, 8'h01);
    // slow-down on, divided tick rate, then off again
    instr(CTL_ADDR, 8'h10, 1'b1);
    wait_slow(1'b1);
    n_ticks = 0;
    repeat (24) begin
      tick(1);
      n_ticks += int'(osc_tick === 1'b1);
    end
    check(8'(n_ticks), 8'h03);
    instr(CTL_ADDR, 8'h00, 1'b1);
    wait_slow(1'b0);
    // pin toggled at run time leaves the watchdog strap alone
    power_fail = 1'b0;
    tick(30);
    check({7'h00, wdt_autostart}, 8'h00);
    instr(CTL_ADDR, 8'h01, 1'b1);
    instr(CTL_ADDR, 8'h20, 1'b1);
    check({7'h00, sleep_active}, 8'h00);
    power_fail = 1'b1;
    tick(30);
    check({7'h00, wdt_autostart}, 8'h00);
    // power-down: both bits at once refused, then the pair
    instr(CTL_ADDR, 8'h42, 1'b1);
    check({7'h00, powerdown_active}, 8'h00);
    instr(CTL_ADDR, 8'h02, 1'b1);
    instr(CTL_ADDR, 8'h40, 1'b1);
    check({4'h0, powerdown_active, periph_clk_en, wdt_halt, port_hold}, 8'h0B);
    wrap_up();
  end
endmodule
